// ---- rtl/dufb_frac_gen.sv ----
// Fractional rate generator: one tick per (divisor + fraction/16) clocks.
// Assumes the caller uses the tick as a 16x oversampling strobe.
`timescale 1ns/1ps
module dufb_frac_gen (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic enable,
   input wire logic [10:0] baud_integer_divisor,
   input wire logic [3:0] baud_fraction,
   output logic tick
);
   import dufb_pkg::*;

   // Period in sixteenths of a clock, never below one whole clock
   logic [15:0] period;
   logic [15:0] eff_period;
   logic [15:0] acc; // Phase accumulator in sixteenths
   logic [15:0] acc_step; // Accumulator after this clock
   logic hit; // Accumulator passed the period
   assign period = {1'b0, baud_integer_divisor, baud_fraction};
   assign eff_period = (period < DUFB_FRAC_STEP) ? DUFB_FRAC_STEP : period;
   assign acc_step = acc + DUFB_FRAC_STEP;
   assign hit = (acc_step >= eff_period);

   // Add one whole each clock, emit a tick and wrap when the period is passed
   always_ff @(posedge ref_clk) begin
      if (!nrst || !enable) begin
         acc <= 16'h0000;
         tick <= 1'b0;
      end else if (hit) begin
         acc <= acc_step - eff_period;
         tick <= 1'b1;
      end else begin
         acc <= acc_step;
         tick <= 1'b0;
      end
   end
endmodule

// ---- rtl/dufb_pkg.sv ----
// Package for the dual serial port block with fractional rate generators.
// Assumes a single 50 MHz clock and 8-bit special function register access.
package dufb_pkg;
   // Register addresses on the special function register bus
   localparam logic [7:0] DUFB_ADDR_CTL1 = 8'hD8; // Control of port 1
   localparam logic [7:0] DUFB_ADDR_BUF1 = 8'hD9; // Data buffer of port 1
   localparam logic [7:0] DUFB_ADDR_BRGH1 = 8'hDA; // Rate high byte, port 1
   localparam logic [7:0] DUFB_ADDR_BRGL1 = 8'hDB; // Rate low byte, port 1
   localparam logic [7:0] DUFB_ADDR_BRGH0 = 8'h9A; // Rate high byte, port 0
   localparam logic [7:0] DUFB_ADDR_BRGL0 = 8'h9B; // Rate low byte, port 0
   // Reset values
   localparam logic [7:0] DUFB_RST_BYTE = 8'h00; // All registers clear at reset
   localparam logic [7:0] DUFB_RST_RD = 8'h00; // Read data when idle or unmapped
   // Field positions of the control register
   localparam int DUFB_SC_MODE_HI = 7; // Mode select, high bit
   localparam int DUFB_SC_MODE_LO = 6; // Mode select, low bit
   localparam int DUFB_SC_MPE = 5; // Multiprocessor enable
   localparam int DUFB_SC_REN = 4; // Receive enable
   localparam int DUFB_SC_TB8 = 3; // Transmit ninth bit
   localparam int DUFB_SC_RB8 = 2; // Received ninth bit
   localparam int DUFB_SC_TI = 1; // Transmit done flag
   localparam int DUFB_SC_RI = 0; // Receive done flag
   localparam int DUFB_BRG_EN_BIT = 7; // Fractional enable in the high byte
   // Operating modes
   typedef enum logic [1:0] {
      DUFB_MODE0 = 2'b00, // Shift register
      DUFB_MODE1 = 2'b01, // 8-bit asynchronous, programmed rate
      DUFB_MODE2 = 2'b10, // 9-bit asynchronous, fixed rate
      DUFB_MODE3 = 2'b11 // 9-bit asynchronous, programmed rate
   } dufb_mode_e;
   // Frame phases shared by transmitter and receiver
   typedef enum logic [2:0] {
      DUFB_IDLE = 3'b000,
      DUFB_START = 3'b001,
      DUFB_DATA = 3'b010,
      DUFB_NINTH = 3'b011,
      DUFB_STOP = 3'b100
   } dufb_phase_e;
   // Timing counts
   localparam logic [3:0] DUFB_M0_LAST = 4'hB; // Mode 0 bit time is 12 clocks
   localparam logic [3:0] DUFB_M0_HALF = 4'h6; // Shift clock rises half way
   localparam logic [3:0] DUFB_PRE_LAST = 4'hB; // Timer prescale of 12
   localparam logic [1:0] DUFB_M2_LAST_DBL = 2'h1; // Mode 2 tick at clock/2
   localparam logic [1:0] DUFB_M2_LAST_STD = 2'h3; // Mode 2 tick at clock/4
   localparam logic [3:0] DUFB_OVS_MID = 4'h7; // Oversample point of a bit
   localparam logic [3:0] DUFB_OVS_LAST = 4'hF; // 16 ticks make one bit
   localparam logic [2:0] DUFB_BIT_LAST = 3'h7; // Eighth data bit index
   localparam logic [15:0] DUFB_TMR_TOP = 16'hFFFF; // Timer overflow value
   localparam logic [15:0] DUFB_FRAC_STEP = 16'h0010; // One whole in sixteenths
   // Pin function select codes for port 0 routing
   localparam logic [1:0] DUFB_PIN_SEL_A = 2'b01;
   localparam logic [1:0] DUFB_PIN_SEL_B = 2'b10;
endpackage

// ---- rtl/dufb_top.sv ----
// Second serial port with control, data buffer and fractional rate generator,
// plus the port 0 rate generator and port 0 pin routing.
// Assumes the CPU drives single-cycle register strobes on ref_clk and that
// port 0's own serial core sits outside and uses baud0_tick.
`timescale 1ns/1ps
module dufb_top (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   output logic [7:0] sfr_rdata,
   input wire logic double_rate_select,
   input wire logic [15:0] timer_reload_value,
   input wire logic rxd1_in,
   output logic rxd1_out,
   output logic rxd1_oe_n,
   output logic txd1_out,
   output logic uart1_irq,
   output logic baud0_tick,
   input wire logic [1:0] pin_func_select_b1,
   input wire logic [1:0] pin_func_select_b7,
   input wire logic uart0_txd,
   output logic uart0_rxd,
   input wire logic gpiob0_in,
   output logic gpiob1_out,
   input wire logic gpiob7_in,
   output logic gpioc0_out
);
   import dufb_pkg::*;

   // Control register fields
   dufb_mode_e mode;
   logic multiproc_enable, rx_enable, tx_ninth_bit, rx_ninth_bit;
   logic tx_done_flag, rx_done_flag;
   logic [7:0] rx_buffer; // Byte last received
   logic [7:0] brg1_hi, brg1_lo, brg0_hi, brg0_lo; // Rate settings
   // Pin synchronisers
   logic rx_s1, rx_s2, b0_s1, b0_s2, b7_s1, b7_s2;

   // Address decode of the register strobes
   wire wr_scon = sfr_wr && (sfr_addr == DUFB_ADDR_CTL1);
   wire wr_sbuf = sfr_wr && (sfr_addr == DUFB_ADDR_BUF1);
   wire wr_brgh1 = sfr_wr && (sfr_addr == DUFB_ADDR_BRGH1);
   wire wr_brgl1 = sfr_wr && (sfr_addr == DUFB_ADDR_BRGL1);
   wire wr_brgh0 = sfr_wr && (sfr_addr == DUFB_ADDR_BRGH0);
   wire wr_brgl0 = sfr_wr && (sfr_addr == DUFB_ADDR_BRGL0);
   wire frac_baud_enable = brg1_hi[DUFB_BRG_EN_BIT];
   wire frac_baud_enable_port0 = brg0_hi[DUFB_BRG_EN_BIT];
   wire is_mode0 = (mode == DUFB_MODE0);

   // Rate ticks
   logic frac_tick; // Port 1 fractional tick
   logic [1:0] m2_cnt; // Mode 2 divider
   logic [3:0] pre_cnt; // Timer prescaler
   logic [15:0] tmr_cnt; // Reload timer
   logic tmr_half; // Halves the timer rate when not doubled
   wire m2_tick = (m2_cnt == (double_rate_select ? DUFB_M2_LAST_DBL : DUFB_M2_LAST_STD));
   wire pre_tick = (pre_cnt == DUFB_PRE_LAST);
   wire tmr_ovf = pre_tick && (tmr_cnt == DUFB_TMR_TOP);
   wire tmr_tick = tmr_ovf && (double_rate_select || tmr_half);
   // Oversampling tick: fixed in mode 2, fractional or timer otherwise
   wire tick16 = (mode == DUFB_MODE2) ? m2_tick :
                 frac_baud_enable ? frac_tick : tmr_tick;

   // Fractional generator for port 1
   dufb_frac_gen u_frac1 (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .enable(frac_baud_enable),
      .baud_integer_divisor({brg1_hi[6:0], brg1_lo[7:4]}),
      .baud_fraction(brg1_lo[3:0]),
      .tick(frac_tick)
   );

   // Fractional generator for port 0, same formula on its own settings
   dufb_frac_gen u_frac0 (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .enable(frac_baud_enable_port0),
      .baud_integer_divisor({brg0_hi[6:0], brg0_lo[7:4]}),
      .baud_fraction(brg0_lo[3:0]),
      .tick(baud0_tick)
   );

   // Fixed and timer dividers, timer reloads on overflow
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         m2_cnt <= 2'h0;
         pre_cnt <= 4'h0;
         tmr_cnt <= 16'h0000;
         tmr_half <= 1'b0;
      end else begin
         m2_cnt <= m2_tick ? 2'h0 : m2_cnt + 2'h1;
         pre_cnt <= pre_tick ? 4'h0 : pre_cnt + 4'h1;
         if (tmr_ovf) begin
            tmr_cnt <= timer_reload_value;
            tmr_half <= ~tmr_half;
         end else if (pre_tick) begin
            tmr_cnt <= tmr_cnt + 16'h0001;
         end
      end
   end

   // Two-flop synchronisers on every pin input
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         {rx_s1, rx_s2, b0_s1, b0_s2, b7_s1, b7_s2} <= 6'h3F;
      end else begin
         rx_s1 <= rxd1_in;
         rx_s2 <= rx_s1;
         b0_s1 <= gpiob0_in;
         b0_s2 <= b0_s1;
         b7_s1 <= gpiob7_in;
         b7_s2 <= b7_s1;
      end
   end

   // Mode 0 shift engine
   logic m0_active, m0_is_tx;
   logic [3:0] m0_cnt; // Clock within the bit time
   logic [2:0] m0_bitn;
   logic [7:0] m0_shift;
   wire m0_bit_end = m0_active && (m0_cnt == DUFB_M0_LAST);
   wire m0_done = m0_bit_end && (m0_bitn == DUFB_BIT_LAST);
   wire m0_rx_go = is_mode0 && rx_enable && !rx_done_flag && !m0_active && !wr_sbuf;

   // Bit time of 12 clocks; transmit has priority over a receive start
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         m0_active <= 1'b0;
         m0_is_tx <= 1'b0;
         m0_cnt <= 4'h0;
         m0_bitn <= 3'h0;
         m0_shift <= DUFB_RST_BYTE;
      end else if (is_mode0 && wr_sbuf) begin
         m0_active <= 1'b1;
         m0_is_tx <= 1'b1;
         m0_cnt <= 4'h0;
         m0_bitn <= 3'h0;
         m0_shift <= sfr_wdata;
      end else if (m0_rx_go) begin
         m0_active <= 1'b1;
         m0_is_tx <= 1'b0;
         m0_cnt <= 4'h0;
         m0_bitn <= 3'h0;
      end else if (m0_active) begin
         m0_cnt <= m0_bit_end ? 4'h0 : m0_cnt + 4'h1;
         // Receive samples the data line on the rising shift clock
         if (!m0_is_tx && (m0_cnt == DUFB_M0_HALF)) begin
            m0_shift <= {rx_s2, m0_shift[7:1]};
         end
         if (m0_bit_end) begin
            m0_bitn <= m0_bitn + 3'h1;
            if (m0_is_tx) begin
               m0_shift <= {1'b1, m0_shift[7:1]};
            end
            if (m0_done || (!m0_is_tx && !rx_enable)) begin
               m0_active <= 1'b0;
            end
         end
      end
   end

   // Asynchronous transmitter, modes 1 to 3
   dufb_phase_e tx_phase;
   logic [3:0] tx_ovs;
   logic [2:0] tx_bitn;
   logic [7:0] tx_shift;
   logic tx_nine;
   logic tx_line;
   wire tx_bit_end = (tx_phase != DUFB_IDLE) && tick16 && (tx_ovs == DUFB_OVS_LAST);
   wire tx_end = tx_bit_end && (tx_phase == DUFB_STOP);

   // Start, data LSB first, optional ninth bit, stop
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         tx_phase <= DUFB_IDLE;
         tx_ovs <= 4'h0;
         tx_bitn <= 3'h0;
         tx_shift <= DUFB_RST_BYTE;
         tx_nine <= 1'b1;
         tx_line <= 1'b1;
      end else if (!is_mode0 && wr_sbuf) begin
         tx_phase <= DUFB_START;
         tx_ovs <= 4'h0;
         tx_bitn <= 3'h0;
         tx_shift <= sfr_wdata;
         tx_nine <= tx_ninth_bit;
         tx_line <= 1'b0;
      end else begin
         if (tick16 && (tx_phase != DUFB_IDLE)) begin
            tx_ovs <= tx_ovs + 4'h1;
         end
         if (tx_bit_end) begin
            case (tx_phase)
               DUFB_START: begin
                  tx_phase <= DUFB_DATA;
                  tx_line <= tx_shift[0];
               end
               DUFB_DATA: begin
                  tx_shift <= {1'b1, tx_shift[7:1]};
                  tx_bitn <= tx_bitn + 3'h1;
                  if (tx_bitn != DUFB_BIT_LAST) begin
                     tx_line <= tx_shift[1];
                  end else if (mode[1]) begin
                     tx_phase <= DUFB_NINTH;
                     tx_line <= tx_nine;
                  end else begin
                     tx_phase <= DUFB_STOP;
                     tx_line <= 1'b1;
                  end
               end
               DUFB_NINTH: begin
                  tx_phase <= DUFB_STOP;
                  tx_line <= 1'b1;
               end
               default: begin
                  tx_phase <= DUFB_IDLE;
                  tx_line <= 1'b1;
               end
            endcase
         end
      end
   end

   // Asynchronous receiver, modes 1 to 3
   dufb_phase_e rx_phase;
   logic [3:0] rx_ovs;
   logic [2:0] rx_bitn;
   logic [7:0] rx_shift;
   logic rx_nine, rx_samp;
   wire rx_run = rx_enable && !is_mode0;
   wire rx_bit_end = (rx_phase != DUFB_IDLE) && tick16 && (rx_ovs == DUFB_OVS_LAST);
   wire rx_end = rx_bit_end && (rx_phase == DUFB_STOP);
   // Mode 1 checks the stop bit, modes 2/3 the ninth bit
   wire rx_addr_ok = !multiproc_enable || (mode[1] ? rx_nine : rx_samp);
   wire rx_load = rx_end && rx_addr_ok && !rx_done_flag;
   wire rx_new_b8 = mode[1] ? rx_nine : rx_samp;

   // Sample each bit at its middle, act at its end
   always_ff @(posedge ref_clk) begin
      if (!nrst || !rx_run) begin
         rx_phase <= DUFB_IDLE;
         rx_ovs <= 4'h0;
         rx_bitn <= 3'h0;
         rx_shift <= DUFB_RST_BYTE;
         rx_nine <= 1'b0;
         rx_samp <= 1'b1;
      end else if (rx_phase == DUFB_IDLE) begin
         if (tick16 && !rx_s2) begin
            rx_phase <= DUFB_START;
            rx_ovs <= 4'h1;
            rx_bitn <= 3'h0;
         end
      end else if (tick16) begin
         rx_ovs <= rx_ovs + 4'h1;
         if (rx_ovs == DUFB_OVS_MID) begin
            rx_samp <= rx_s2;
            // A start bit gone high by its middle was noise
            if ((rx_phase == DUFB_START) && rx_s2) begin
               rx_phase <= DUFB_IDLE;
            end
         end
         if (rx_bit_end) begin
            case (rx_phase)
               DUFB_START: rx_phase <= DUFB_DATA;
               DUFB_DATA: begin
                  rx_shift <= {rx_samp, rx_shift[7:1]};
                  rx_bitn <= rx_bitn + 3'h1;
                  if (rx_bitn == DUFB_BIT_LAST) begin
                     rx_phase <= mode[1] ? DUFB_NINTH : DUFB_STOP;
                  end
               end
               DUFB_NINTH: begin
                  rx_nine <= rx_samp;
                  rx_phase <= DUFB_STOP;
               end
               default: rx_phase <= DUFB_IDLE;
            endcase
         end
      end
   end

   // Next values of the done flags: a hardware set wins over a clear
   wire set_ti = tx_end || (m0_done && m0_is_tx);
   wire set_ri = rx_load || (m0_done && !m0_is_tx);
   wire next_ti = set_ti || (wr_scon ? sfr_wdata[DUFB_SC_TI] : tx_done_flag);
   wire next_ri = set_ri || (wr_scon ? sfr_wdata[DUFB_SC_RI] : rx_done_flag);

   // Control, buffer and rate registers
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         mode <= DUFB_MODE0;
         {multiproc_enable, rx_enable, tx_ninth_bit, rx_ninth_bit} <= 4'h0;
         tx_done_flag <= 1'b0;
         rx_done_flag <= 1'b0;
         rx_buffer <= DUFB_RST_BYTE;
         brg1_hi <= DUFB_RST_BYTE;
         brg1_lo <= DUFB_RST_BYTE;
         brg0_hi <= DUFB_RST_BYTE;
         brg0_lo <= DUFB_RST_BYTE;
      end else begin
         tx_done_flag <= next_ti;
         rx_done_flag <= next_ri;
         if (wr_scon) begin
            mode <= dufb_mode_e'(sfr_wdata[DUFB_SC_MODE_HI:DUFB_SC_MODE_LO]);
            multiproc_enable <= sfr_wdata[DUFB_SC_MPE];
            rx_enable <= sfr_wdata[DUFB_SC_REN];
            tx_ninth_bit <= sfr_wdata[DUFB_SC_TB8];
            rx_ninth_bit <= sfr_wdata[DUFB_SC_RB8];
         end
         // Received byte and ninth bit land together with the flag
         if (rx_load) begin
            rx_buffer <= rx_shift;
            rx_ninth_bit <= rx_new_b8;
         end else if (m0_done && !m0_is_tx) begin
            rx_buffer <= m0_shift;
         end
         if (wr_brgh1) brg1_hi <= sfr_wdata;
         if (wr_brgl1) brg1_lo <= sfr_wdata;
         if (wr_brgh0) brg0_hi <= sfr_wdata;
         if (wr_brgl0) brg0_lo <= sfr_wdata;
      end
   end

   // Read selection; the data buffer returns the received byte
   wire [7:0] scon_rd = {mode, multiproc_enable, rx_enable, tx_ninth_bit,
                         rx_ninth_bit, tx_done_flag, rx_done_flag};
   wire [7:0] rd_mux = (sfr_addr == DUFB_ADDR_CTL1) ? scon_rd :
                       (sfr_addr == DUFB_ADDR_BUF1) ? rx_buffer :
                       (sfr_addr == DUFB_ADDR_BRGH1) ? brg1_hi :
                       (sfr_addr == DUFB_ADDR_BRGL1) ? brg1_lo :
                       (sfr_addr == DUFB_ADDR_BRGH0) ? brg0_hi :
                       (sfr_addr == DUFB_ADDR_BRGL0) ? brg0_lo : DUFB_RST_RD;

   // Pin drive: mode 0 puts the shift clock on tx and data on rx
   wire m0_tx_drive = m0_active && m0_is_tx;
   wire next_txd1 = m0_active ? (m0_cnt >= DUFB_M0_HALF) :
                    (is_mode0 || tx_line);
   wire next_rxd1 = m0_tx_drive ? m0_shift[0] : 1'b1;
   wire sel_a = (pin_func_select_b1 == DUFB_PIN_SEL_A);
   wire sel_b = (pin_func_select_b7 == DUFB_PIN_SEL_B);

   // Registered outputs
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         sfr_rdata <= DUFB_RST_RD;
         txd1_out <= 1'b1;
         rxd1_out <= 1'b1;
         rxd1_oe_n <= 1'b1;
         uart1_irq <= 1'b0;
         uart0_rxd <= 1'b1;
         gpiob1_out <= 1'b1;
         gpioc0_out <= 1'b1;
      end else begin
         sfr_rdata <= sfr_rd ? rd_mux : DUFB_RST_RD;
         txd1_out <= next_txd1;
         rxd1_out <= next_rxd1;
         rxd1_oe_n <= !m0_tx_drive;
         uart1_irq <= next_ti || next_ri;
         // Port 0 routing, pair A wins when both are selected
         uart0_rxd <= sel_a ? b0_s2 : (sel_b ? b7_s2 : 1'b1);
         gpiob1_out <= sel_a ? uart0_txd : 1'b1;
         gpioc0_out <= (sel_b && !sel_a) ? uart0_txd : 1'b1;
      end
   end
endmodule

// ---- test/dufb_checker.sv ----
// Checker for the serial port top: bus answers, flags and line timing.
// Assumes one clock and mirrors of what software wrote to control and rate.
`timescale 1ns/1ps
module dufb_checker (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_rdata,
   input wire logic rxd1_oe_n,
   input wire logic txd1_out,
   input wire logic uart1_irq,
   input wire logic baud0_tick
);
   import dufb_pkg::*;
   logic [7:0] ctl_q; // Last control byte written
   logic [15:0] brg0_q; // Port 0 rate bytes, high then low
   logic wr_ctl; // Control register write
   logic known; // Address is mapped
   logic m0; // Shift register mode selected
   assign wr_ctl = sfr_wr && (sfr_addr == DUFB_ADDR_CTL1);
   assign m0 = (ctl_q[7:6] == DUFB_MODE0);
   assign known = sfr_addr inside {DUFB_ADDR_CTL1, DUFB_ADDR_BUF1, DUFB_ADDR_BRGH1,
      DUFB_ADDR_BRGL1, DUFB_ADDR_BRGH0, DUFB_ADDR_BRGL0};
   // Mirrors software writes
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         ctl_q <= 8'h00;
         brg0_q <= 16'h0000;
      end else begin
         if (wr_ctl) begin
            ctl_q <= sfr_wdata;
         end
         if (sfr_wr && sfr_addr == DUFB_ADDR_BRGH0) begin
            brg0_q[15:8] <= sfr_wdata;
         end
         if (sfr_wr && sfr_addr == DUFB_ADDR_BRGL0) begin
            brg0_q[7:0] <= sfr_wdata;
         end
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   property p_rd_none; sfr_rd && !known |=> sfr_rdata == DUFB_RST_RD; endproperty
   a_rd_none: assert property (p_rd_none) else $error("unmapped read not zero");
   property p_rd_idle; !sfr_rd |=> sfr_rdata == DUFB_RST_RD; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
   property p_ctl; sfr_rd && sfr_addr == DUFB_ADDR_CTL1
      |=> sfr_rdata[7:3] == ctl_q[7:3]; endproperty
   a_ctl: assert property (p_ctl) else $error("control bits changed");
   property p_irq_hold; uart1_irq && !wr_ctl |=> uart1_irq; endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("flag cleared alone");
   property p_oe; !rxd1_oe_n |-> m0; endproperty
   a_oe: assert property (p_oe) else $error("data pin driven outside mode 0");
   property p_start; sfr_wr && sfr_addr == DUFB_ADDR_BUF1 && !m0 |-> ##[1:2] !txd1_out;
   endproperty
   a_start: assert property (p_start) else $error("no start bit");
   property p_bit; $fell(txd1_out) && !m0 |-> !txd1_out [*8]; endproperty
   a_bit: assert property (p_bit) else $error("low bit too short");
   property p_m0_low; $fell(txd1_out) && m0 |-> !txd1_out [*6] ##1 txd1_out; endproperty
   a_m0_low: assert property (p_m0_low) else $error("shift clock low wrong");
   property p_m0_high; $rose(txd1_out) && m0 |-> txd1_out [*6]; endproperty
   a_m0_high: assert property (p_m0_high) else $error("shift clock high short");
   property p_tick0; baud0_tick && brg0_q == 16'h8040 |=> !baud0_tick [*3] ##1 baud0_tick;
   endproperty
   a_tick0: assert property (p_tick0) else $error("port 0 tick spacing");
endmodule
bind dufb_top dufb_checker i_dufb_checker (.ref_clk(ref_clk), .nrst(nrst),
   .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
   .sfr_rdata(sfr_rdata), .rxd1_oe_n(rxd1_oe_n), .txd1_out(txd1_out),
   .uart1_irq(uart1_irq), .baud0_tick(baud0_tick));

// ---- test/dufb_remote.sv ----
// Remote serial device on port 1: captures frames from the transmit pin
// and sends frames to the receive pin. Assumes the bench sets the bit time.
`timescale 1ns/1ps
module dufb_remote (
   input wire logic ref_clk,
   input wire logic txd,
   input wire logic [3:0] frame_bits,
   input wire logic [7:0] bit_clks,
   output logic rxd,
   output logic [10:0] got_frame,
   output logic [7:0] got_cnt
);
   initial begin
      rxd = 1'b1;
      got_frame = 11'h7FF;
      got_cnt = 8'h00;
   end
   // Samples mid-bit, first bit on the wire into bit 0
   always begin
      @(negedge txd);
      got_frame = 11'h7FF;
      repeat (bit_clks / 2) @(posedge ref_clk);
      for (int i = 0; i < frame_bits; i++) begin
         got_frame[i] = txd;
         repeat (bit_clks) @(posedge ref_clk);
      end
      got_cnt = got_cnt + 8'h01;
   end
   // Sends one frame first bit first; line idles high on the stop level
   task automatic send(input logic [10:0] fr, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge ref_clk);
         rxd <= fr[i];
         repeat (bit_clks - 1) @(posedge ref_clk);
      end
   endtask
endmodule

// ---- test/dufb_top_tb_top.sv ----
// Testbench for the serial port block: register tasks and table-driven frames.
// Assumes the checker is bound to the top and the remote device sits on port 1.
`timescale 1ns/1ps
module dufb_top_tb_top;
   import dufb_pkg::*;
   logic ref_clk = 1'b0, nrst = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, bit_clks = 8'h20, got_cnt;
   logic double_rate_select = 1'b0, uart0_txd = 1'b1, gpiob0_in = 1'b1, gpiob7_in = 1'b1;
   logic [1:0] pin_func_select_b1 = 2'b00, pin_func_select_b7 = 2'b00;
   logic [3:0] frame_bits = 4'hA;
   logic [10:0] got_frame;
   logic rx_pin, remote_rxd, rxd1_out, rxd1_oe_n, txd1_out, uart1_irq, uart0_rxd;
   logic gpiob1_out, gpioc0_out;
   int n_errors = 0, samples_checked = 0, cycles = 0;
   logic [7:0] t_ctl [4] = '{8'h40, 8'hC8, 8'h88, 8'h80}; // Transmit modes
   logic [7:0] t_dat [4] = '{8'hA5, 8'h3C, 8'h5A, 8'h0F};
   logic [7:0] t_bit [4] = '{8'h20, 8'h20, 8'h40, 8'h20}; // Clocks per bit
   logic [7:0] r_ctl [4] = '{8'h40, 8'hF0, 8'h50, 8'hF0}; // Receive setups
   logic [7:0] r_dat [4] = '{8'h69, 8'h11, 8'h69, 8'h22};
   logic [7:0] r_exp [4] = '{8'h40, 8'hF0, 8'h55, 8'hF5};
   logic [3:0] r_nin = 4'b1101; // Ninth or stop bit per receive case
   // Open-drain style data pin: the block wins while it drives
   assign rx_pin = rxd1_oe_n ? remote_rxd : rxd1_out;
   always #10 ref_clk = ~ref_clk;
   dufb_top i_dufb_top (.ref_clk(ref_clk), .nrst(nrst), .sfr_addr(sfr_addr),
      .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
      .double_rate_select(double_rate_select), .timer_reload_value(16'hFFF0),
      .rxd1_in(rx_pin), .rxd1_out(rxd1_out), .rxd1_oe_n(rxd1_oe_n), .txd1_out(txd1_out),
      .uart1_irq(uart1_irq), .baud0_tick(), .pin_func_select_b1(pin_func_select_b1),
      .pin_func_select_b7(pin_func_select_b7), .uart0_txd(uart0_txd), .uart0_rxd(uart0_rxd),
      .gpiob0_in(gpiob0_in), .gpiob1_out(gpiob1_out), .gpiob7_in(gpiob7_in),
      .gpioc0_out(gpioc0_out));
   dufb_remote i_dufb_remote (.ref_clk(ref_clk), .txd(txd1_out), .frame_bits(frame_bits),
      .bit_clks(bit_clks), .rxd(remote_rxd), .got_frame(got_frame), .got_cnt(got_cnt));
   // Counts and reports one comparison
   task automatic chk(input string nm, input logic [10:0] got, input logic [10:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Single-cycle register write
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge ref_clk);
      sfr_wr <= 1'b0;
   endtask
   // Register read; answer is taken the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      sfr_addr <= a;
      sfr_rd <= 1'b1;
      @(posedge ref_clk);
      sfr_rd <= 1'b0;
      @(negedge ref_clk);
      chk($sformatf("register %h", a), {3'b000, sfr_rdata}, {3'b000, exp});
      @(posedge ref_clk);
   endtask
   task automatic print_verdict();
      $display("checked %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Cuts a hung run short
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         n_errors++;
         print_verdict();
      end
   end
   initial begin
      logic [7:0] c0;
      repeat (16) @(posedge ref_clk);
      nrst <= 1'b1;
      rd(DUFB_ADDR_CTL1, DUFB_RST_BYTE);
      rd(DUFB_ADDR_BRGH1, DUFB_RST_BYTE);
      rd(8'h00, DUFB_RST_RD);
      wr(DUFB_ADDR_BRGH1, 8'h80);
      wr(DUFB_ADDR_BRGL1, 8'h20);
      wr(DUFB_ADDR_BRGH0, 8'h00);
      wr(DUFB_ADDR_BRGL0, 8'h40);
      wr(DUFB_ADDR_BRGH0, 8'h80);
      wr(DUFB_ADDR_BRGL0, 8'h40);
      rd(DUFB_ADDR_BRGL1, 8'h20);
      rd(DUFB_ADDR_BRGH0, 8'h80);
      $display("test registers done");
      // Transmit in modes 1, 3 and 2 at both fixed rates
      for (int i = 0; i < 4; i++) begin
         double_rate_select <= i[1] & i[0];
         bit_clks <= t_bit[i];
         frame_bits <= t_ctl[i][7] ? 4'hB : 4'hA;
         wr(DUFB_ADDR_CTL1, t_ctl[i]);
         c0 = got_cnt;
         wr(DUFB_ADDR_BUF1, t_dat[i]);
         for (int w = 0; w < 1200 && got_cnt == c0; w++) @(posedge ref_clk);
         chk("frame", got_frame, {1'b1, t_ctl[i][7] ? t_ctl[i][3] : 1'b1, t_dat[i], 1'b0});
         repeat (40) @(posedge ref_clk);
         rd(DUFB_ADDR_CTL1, t_ctl[i] | 8'h02);
         chk("irq", {10'h000, uart1_irq}, 11'h001);
         wr(DUFB_ADDR_CTL1, t_ctl[i]);
         rd(DUFB_ADDR_CTL1, t_ctl[i]);
         $display("test transmit %0d done", i);
      end
      // Receive: enable off, multiprocessor refusal, mode 1, multiprocessor accept
      for (int i = 0; i < 4; i++) begin
         wr(DUFB_ADDR_CTL1, r_ctl[i]);
         i_dufb_remote.send({1'b1, r_nin[i], r_dat[i], 1'b0}, r_ctl[i][7] ? 11 : 10);
         repeat (60) @(posedge ref_clk);
         rd(DUFB_ADDR_CTL1, r_exp[i]);
         if (r_exp[i][0]) begin
            rd(DUFB_ADDR_BUF1, r_dat[i]);
         end
         wr(DUFB_ADDR_CTL1, r_ctl[i]);
         $display("test receive %0d done", i);
      end
      // Shift register mode: flag after eight bits of twelve clocks
      wr(DUFB_ADDR_CTL1, 8'h00);
      wr(DUFB_ADDR_BUF1, 8'hC3);
      repeat (84) @(posedge ref_clk);
      chk("shift data", {9'h000, rxd1_oe_n, rxd1_out}, 11'h001);
      rd(DUFB_ADDR_CTL1, 8'h00);
      repeat (20) @(posedge ref_clk);
      rd(DUFB_ADDR_CTL1, 8'h02);
      chk("pin enable", {10'h000, rxd1_oe_n}, 11'h001);
      $display("test shift done");
      // Port 0 routing to pair A, then pair B
      uart0_txd <= 1'b0;
      gpiob0_in <= 1'b0;
      pin_func_select_b1 <= DUFB_PIN_SEL_A;
      repeat (6) @(posedge ref_clk);
      chk("pair a", {8'h00, uart0_rxd, gpiob1_out, gpioc0_out}, 11'h001);
      gpiob0_in <= 1'b1;
      gpiob7_in <= 1'b0;
      pin_func_select_b1 <= 2'b00;
      pin_func_select_b7 <= DUFB_PIN_SEL_B;
      repeat (6) @(posedge ref_clk);
      chk("pair b", {8'h00, uart0_rxd, gpiob1_out, gpioc0_out}, 11'h002);
      $display("test routing done");
      print_verdict();
   end
endmodule
